/* File: inc/cgr_cfg.svh */
// register offsets, field positions and reset values of the clock generator config bank
`ifndef CGR_CFG_SVH
`define CGR_CFG_SVH

`define CGR_OFS_DIV1_LOW   8'h08
`define CGR_OFS_SPREAD     8'h09
`define CGR_OFS_STATUS     8'h0A

`define CGR_DIV1_RST       16'hC28F
`define CGR_TAG_RST        4'h3
`define CGR_SPREAD_RST     3'h0
`define CGR_SPR_RSV_RST    9'h000
`define CGR_IDLE_RST       1'b1
`define CGR_INHIBIT_RST    1'b0
`define CGR_AUTOLOAD_RST   1'b0
`define CGR_PDN_RST        1'b0

`define CGR_TAG_MSB        15
`define CGR_TAG_LSB        12
`define CGR_SPR_MSB        11
`define CGR_SPR_LSB        9
`define CGR_SPR_RSV_MSB    8
`define CGR_SPR_RSV_LSB    0

`define CGR_ST_RSV15       15
`define CGR_ST_REV_MSB     14
`define CGR_ST_REV_LSB     11
`define CGR_ST_CLKOK       10
`define CGR_ST_REFPIN      8
`define CGR_ST_SEL1        7
`define CGR_ST_SEL0        6
`define CGR_ST_ADDR        5
`define CGR_ST_IDLE        4
`define CGR_ST_INHIBIT     3
`define CGR_ST_AUTOLOAD    2
`define CGR_ST_PDN         1
`define CGR_ST_RSV0        0

`define CGR_SPR_CUSTOM     3'h0
`define CGR_SPR_MAX_PRESET 3'h4
`define CGR_REF_FUNC_READY 2'h3

`endif

/* File: inc/cgr_pkg.sv */
// types shared by the clock generator config bank and its power control
package cgr_pkg;

	typedef enum logic [1:0] {
		CGR_PWR_INIT,
		CGR_PWR_ACTIVE,
		CGR_PWR_LOW,
		CGR_PWR_EXIT
	} cgr_pwr_state_t;

	typedef struct packed {
		cgr_pwr_state_t state;
		logic           low_power;
		logic           preprog;
		logic           addr_s;
		logic           sel0_s;
		logic           sel1_s;
		logic           exit_pulse;
	} cgr_pwr_t;

	typedef struct packed {
		logic [15:0] div1_num;
		logic [3:0]  tag;
		logic [2:0]  spread_sel;
		logic [8:0]  spread_rsv;
		logic        st_rsv15;
		logic        idle_sel;
		logic        rescan_inh;
		logic        autoload_dis;
		logic        power_down_request;
		logic        st_rsv0;
		logic [15:0] rdata;
		logic        rvalid;
		logic        spread_custom;
		logic        spread_preset;
		logic        ref_pin_out;
		logic        ref_pin_oe;
		logic        outputs_mute;
	} cgr_regs_t;

endpackage : cgr_pkg

/* File: logic/cgr_power_ctrl.sv */
// low-power entry and exit sequencing with strap capture
`timescale 1ns/1ps
`include "cgr_cfg.svh"

module cgr_power_ctrl
	import cgr_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic lp_req,
	input  wire logic rescan_inh,
	input  wire logic address_strap_level,
	input  wire logic select0_pin_level,
	input  wire logic select1_pin_level,
	output logic      low_power,
	output logic      preprog_mode,
	output logic      strap_addr,
	output logic      strap_sel0,
	output logic      strap_sel1,
	output logic      exit_pulse
);

	cgr_pwr_t st_ff;
	cgr_pwr_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.exit_pulse = 1'b0;
		case (st_ff.state)
			CGR_PWR_INIT: begin
				// straps are caught after reset release, not by the reset itself
				nxt_st.addr_s  = address_strap_level;
				nxt_st.sel0_s  = select0_pin_level;
				nxt_st.sel1_s  = select1_pin_level;
				nxt_st.preprog = address_strap_level;
				nxt_st.state   = CGR_PWR_ACTIVE;
			end
			CGR_PWR_ACTIVE: begin
				if (lp_req) begin
					nxt_st.low_power = 1'b1;
					nxt_st.state     = CGR_PWR_LOW;
				end
			end
			CGR_PWR_LOW: begin
				if (!lp_req) begin
					nxt_st.state = CGR_PWR_EXIT;
				end
			end
			CGR_PWR_EXIT: begin
				nxt_st.low_power  = 1'b0;
				nxt_st.exit_pulse = 1'b1;
				if (!rescan_inh) begin
					nxt_st.addr_s  = address_strap_level;
					nxt_st.sel0_s  = select0_pin_level;
					nxt_st.sel1_s  = select1_pin_level;
					nxt_st.preprog = address_strap_level;
				end else begin
					nxt_st.preprog = 1'b0;
				end
				nxt_st.state = CGR_PWR_ACTIVE;
			end
			default: begin
				nxt_st.state = CGR_PWR_INIT;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= '{state: CGR_PWR_INIT, default: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign low_power    = st_ff.low_power;
	assign preprog_mode = st_ff.preprog;
	assign strap_addr   = st_ff.addr_s;
	assign strap_sel0   = st_ff.sel0_s;
	assign strap_sel1   = st_ff.sel1_s;
	assign exit_pulse   = st_ff.exit_pulse;

	// ==========================================================
	// checks
	sequence lp_leave_s;
		st_ff.state == CGR_PWR_LOW && !lp_req;
	endsequence

	sequence lp_enter_s;
		st_ff.state == CGR_PWR_ACTIVE && lp_req;
	endsequence

	exit_rescan_a: assert property (@(posedge core_clk) disable iff (rst)
		(lp_leave_s ##1 !rescan_inh) |=> (preprog_mode == $past(address_strap_level)))
		else $error("strap rescan did not follow address strap on exit");

	exit_inhibit_a: assert property (@(posedge core_clk) disable iff (rst)
		(lp_leave_s ##1 rescan_inh) |=> (!preprog_mode && exit_pulse && !low_power))
		else $error("inhibited exit left serial-bus mode");

	lp_entry_a: assert property (@(posedge core_clk) disable iff (rst)
		lp_enter_s |=> low_power ##1 (low_power || exit_pulse))
		else $error("low power request not honoured");

endmodule : cgr_power_ctrl

/* File: logic/cgr_config_regs.sv */
// divider, spread/tag and status/idle register bank of the clock generator
`timescale 1ns/1ps
`include "cgr_cfg.svh"

module cgr_config_regs
	import cgr_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr_en,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_rd_en,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        fuse_load,
	input  wire logic [15:0] fuse_div1_num,
	input  wire logic [3:0]  fuse_tag,
	input  wire logic [2:0]  fuse_spread_sel,
	input  wire logic        fuse_idle_sel,
	input  wire logic [3:0]  product_revision,
	input  wire logic        clk_ok,
	input  wire logic        ref_pin_level,
	input  wire logic        select1_pin_level,
	input  wire logic        select0_pin_level,
	input  wire logic        address_strap_level,
	input  wire logic [1:0]  ref_pin_func,
	input  wire logic        outputs_disabled,
	output logic      [15:0] divider1_numerator,
	output logic      [3:0]  config_image_tag,
	output logic      [2:0]  spread_profile_select,
	output logic             spread_custom,
	output logic             spread_preset,
	output logic             ref_pin_out,
	output logic             ref_pin_oe,
	output logic             outputs_mute,
	output logic             low_power,
	output logic             preprog_mode,
	output logic             strap_addr,
	output logic             strap_sel0,
	output logic             strap_sel1,
	output logic             lp_exit_pulse
);

	// ==========================================================
	// helpers
	function automatic logic cgr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		cgr_hit = (addr == ofs);
	endfunction : cgr_hit

	// returns {custom, preset}; reserved codes give neither
	function automatic logic [1:0] cgr_spread_decode(input logic [2:0] sel);
		logic custom;
		logic preset;
		custom = (sel == `CGR_SPR_CUSTOM);
		preset = !custom && (sel <= `CGR_SPR_MAX_PRESET);
		cgr_spread_decode = {custom, preset};
	endfunction : cgr_spread_decode

	cgr_regs_t st_ff;
	cgr_regs_t nxt_st;
	logic      lp_req;

	// ==========================================================
	// next state
	always_comb begin
		logic [15:0] status_word;
		logic [15:0] spread_word;
		logic [1:0]  spr_dec;
		status_word = 16'h0000;
		spread_word = 16'h0000;
		spr_dec     = 2'b00;
		nxt_st      = st_ff;
		nxt_st.rvalid = 1'b0;

		// fuse restore first so that a same-cycle host write lands on top
		if (fuse_load) begin
			nxt_st.div1_num   = fuse_div1_num;
			nxt_st.tag        = fuse_tag;
			nxt_st.spread_sel = fuse_spread_sel;
			nxt_st.idle_sel   = fuse_idle_sel;
		end

		if (reg_wr_en) begin
			if (cgr_hit(reg_addr, `CGR_OFS_DIV1_LOW)) begin
				nxt_st.div1_num = reg_wdata;
			end
			if (cgr_hit(reg_addr, `CGR_OFS_SPREAD)) begin
				nxt_st.tag        = reg_wdata[`CGR_TAG_MSB:`CGR_TAG_LSB];
				nxt_st.spread_sel = reg_wdata[`CGR_SPR_MSB:`CGR_SPR_LSB];
				nxt_st.spread_rsv = reg_wdata[`CGR_SPR_RSV_MSB:`CGR_SPR_RSV_LSB];
			end
			if (cgr_hit(reg_addr, `CGR_OFS_STATUS)) begin
				// revision, clock-ok and pin readbacks are never stored
				nxt_st.st_rsv15     = reg_wdata[`CGR_ST_RSV15];
				nxt_st.idle_sel     = reg_wdata[`CGR_ST_IDLE];
				nxt_st.rescan_inh   = reg_wdata[`CGR_ST_INHIBIT];
				nxt_st.autoload_dis = reg_wdata[`CGR_ST_AUTOLOAD];
				nxt_st.power_down_request          = reg_wdata[`CGR_ST_PDN];
				nxt_st.st_rsv0      = reg_wdata[`CGR_ST_RSV0];
			end
		end

		status_word[`CGR_ST_RSV15] = st_ff.st_rsv15;
		status_word[`CGR_ST_REV_MSB:`CGR_ST_REV_LSB] = product_revision;
		status_word[`CGR_ST_CLKOK]    = clk_ok;
		status_word[`CGR_ST_REFPIN]   = ref_pin_level;
		status_word[`CGR_ST_SEL1]     = select1_pin_level;
		status_word[`CGR_ST_SEL0]     = select0_pin_level;
		status_word[`CGR_ST_ADDR]     = address_strap_level;
		status_word[`CGR_ST_IDLE]     = st_ff.idle_sel;
		status_word[`CGR_ST_INHIBIT]  = st_ff.rescan_inh;
		status_word[`CGR_ST_AUTOLOAD] = st_ff.autoload_dis;
		status_word[`CGR_ST_PDN]      = st_ff.power_down_request;
		status_word[`CGR_ST_RSV0]     = st_ff.st_rsv0;

		spread_word[`CGR_TAG_MSB:`CGR_TAG_LSB] = st_ff.tag;
		spread_word[`CGR_SPR_MSB:`CGR_SPR_LSB] = st_ff.spread_sel;
		spread_word[`CGR_SPR_RSV_MSB:`CGR_SPR_RSV_LSB] = st_ff.spread_rsv;

		// read returns the value held before a same-cycle write
		if (reg_rd_en) begin
			nxt_st.rvalid = 1'b1;
			if (cgr_hit(reg_addr, `CGR_OFS_DIV1_LOW)) begin
				nxt_st.rdata = st_ff.div1_num;
			end else if (cgr_hit(reg_addr, `CGR_OFS_SPREAD)) begin
				nxt_st.rdata = spread_word;
			end else if (cgr_hit(reg_addr, `CGR_OFS_STATUS)) begin
				nxt_st.rdata = status_word;
			end else begin
				nxt_st.rdata = 16'h0000;
			end
		end

		spr_dec = cgr_spread_decode(nxt_st.spread_sel);
		nxt_st.spread_custom = spr_dec[1];
		nxt_st.spread_preset = spr_dec[0];

		if (ref_pin_func == `CGR_REF_FUNC_READY) begin
			nxt_st.ref_pin_out = clk_ok;
			nxt_st.ref_pin_oe  = 1'b1;
		end else begin
			nxt_st.ref_pin_out = 1'b0;
			nxt_st.ref_pin_oe  = 1'b0;
		end

		// muting happens in either idle behaviour
		nxt_st.outputs_mute = outputs_disabled;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff <= '{div1_num:     `CGR_DIV1_RST,
			           tag:          `CGR_TAG_RST,
			           spread_sel:   `CGR_SPREAD_RST,
			           spread_rsv:   `CGR_SPR_RSV_RST,
			           idle_sel:     `CGR_IDLE_RST,
			           rescan_inh:   `CGR_INHIBIT_RST,
			           autoload_dis: `CGR_AUTOLOAD_RST,
			           power_down_request:          `CGR_PDN_RST,
			           spread_custom: 1'b1,
			           default:      '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// low power only when idle select is 0; a host power-down always wins
	assign lp_req = st_ff.power_down_request || (st_ff.outputs_mute && !st_ff.idle_sel);

	cgr_power_ctrl u_power (
		.core_clk            (core_clk),
		.rst                 (rst),
		.lp_req              (lp_req),
		.rescan_inh          (st_ff.rescan_inh),
		.address_strap_level (address_strap_level),
		.select0_pin_level   (select0_pin_level),
		.select1_pin_level   (select1_pin_level),
		.low_power           (low_power),
		.preprog_mode        (preprog_mode),
		.strap_addr          (strap_addr),
		.strap_sel0          (strap_sel0),
		.strap_sel1          (strap_sel1),
		.exit_pulse          (lp_exit_pulse)
	);

	assign reg_rdata             = st_ff.rdata;
	assign reg_rvalid            = st_ff.rvalid;
	assign divider1_numerator    = st_ff.div1_num;
	assign config_image_tag      = st_ff.tag;
	assign spread_profile_select = st_ff.spread_sel;
	assign spread_custom         = st_ff.spread_custom;
	assign spread_preset         = st_ff.spread_preset;
	assign ref_pin_out           = st_ff.ref_pin_out;
	assign ref_pin_oe            = st_ff.ref_pin_oe;
	assign outputs_mute          = st_ff.outputs_mute;

	// ==========================================================
	// checks
	div1_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd_en && reg_addr == `CGR_OFS_DIV1_LOW) |=>
		(reg_rvalid && reg_rdata == $past(st_ff.div1_num)))
		else $error("numerator readback wrong");

	div1_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_wr_en && reg_addr == `CGR_OFS_DIV1_LOW) |=> (divider1_numerator == $past(reg_wdata)))
		else $error("numerator write lost");

	tag_write_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_wr_en && reg_addr == `CGR_OFS_SPREAD) |=>
		(config_image_tag == $past(reg_wdata[15:12])))
		else $error("config tag write lost");

	spread_decode_a: assert property (@(posedge core_clk) disable iff (rst)
		spread_custom == (spread_profile_select == 3'h0) &&
		spread_preset == (spread_profile_select inside {3'h1, 3'h2, 3'h3, 3'h4}))
		else $error("spread decode wrong");

	ready_mirror_a: assert property (@(posedge core_clk) disable iff (rst)
		(ref_pin_func == 2'h3) |=> (ref_pin_oe && ref_pin_out == $past(clk_ok)))
		else $error("reference pin does not mirror clock ok");

	pin_readback_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd_en && reg_addr == `CGR_OFS_STATUS) |=>
		(reg_rdata[10:5] == {$past(clk_ok), 1'b0, $past(ref_pin_level),
		 $past(select1_pin_level), $past(select0_pin_level), $past(address_strap_level)}))
		else $error("status readback wrong");

	idle_lowpower_a: assert property (@(posedge core_clk) disable iff (rst)
		(outputs_disabled && !st_ff.idle_sel && !st_ff.power_down_request && !reg_wr_en) [*3] |=>
		(outputs_mute && low_power))
		else $error("idle select 0 did not enter low power");

	readonly_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd_en && reg_addr == `CGR_OFS_STATUS) |=>
		(reg_rdata[14:11] == $past(product_revision)))
		else $error("revision field took a write");

	pdn_entry_a: assert property (@(posedge core_clk) disable iff (rst)
		(reg_wr_en && reg_addr == `CGR_OFS_STATUS && reg_wdata[1]) ##1
		(st_ff.power_down_request && !reg_wr_en) [*3] |-> low_power)
		else $error("power down write did not reach low power");

endmodule : cgr_config_regs

/* File: dv/cgr_host_model.sv */
// host-side register access model for the clock generator config bank
`timescale 1ns/1ps

module cgr_host_model (
	input  wire logic        core_clk,
	output logic      [7:0]  reg_addr,
	output logic             reg_wr_en,
	output logic      [15:0] reg_wdata,
	output logic             reg_rd_en,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd_en = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		if (a == 8'h09) v[8:0] = 9'h000;
		if (a == 8'h0A) v[15] = 1'b0;
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_wdata <= ~v;
	endtask : wr

	// answer may come slowly; give up after four edges and hand back unknown
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		d = 16'hXXXX;
		for (int i = 0; i < 4; i++) begin
			#1;
			if (reg_rvalid === 1'b1) begin
				d = reg_rdata;
				break;
			end
			@(posedge core_clk);
		end
	endtask : rd
endmodule : cgr_host_model

/* File: dv/clockgen_config_status_regs_tb_top.sv */
// self-checking bench of the clock generator config bank
`timescale 1ns/1ps

module clockgen_config_status_regs_tb_top;
	logic        core_clk;
	logic        rst = 1'b1;
	logic        fuse_load = 1'b0;
	logic [15:0] fuse_div1_num = 16'h0000;
	logic [3:0]  fuse_tag = 4'h0;
	logic [2:0]  fuse_spread_sel = 3'h0;
	logic        fuse_idle_sel = 1'b0;
	logic [3:0]  product_revision = 4'h5;
	logic        clk_ok = 1'b0;
	logic        ref_pin_level = 1'b0;
	logic        select1_pin_level = 1'b0;
	logic        select0_pin_level = 1'b0;
	logic        address_strap_level = 1'b0;
	logic [1:0]  ref_pin_func = 2'h0;
	logic        outputs_disabled = 1'b0;
	logic [7:0]  reg_addr;
	logic        reg_wr_en, reg_rd_en, reg_rvalid;
	logic [15:0] reg_wdata, reg_rdata, div_o;
	logic [3:0]  tag_o;
	logic [2:0]  spr_o;
	logic        spread_custom, spread_preset, ref_pin_out, ref_pin_oe, outputs_mute;
	logic        low_power, preprog_mode, lp_exit_pulse;
	logic        strap_addr, strap_sel0, strap_sel1;
	logic [15:0] lf = 16'h005B;
	int          m_div = 'hC28F, m_tag = 3, m_spr = 0, m_st = 'h10;
	int          err_total = 0, checked = 0, exits = 0;

	// ==========================================================
	// clock, partner and design
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	cgr_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	cgr_config_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fuse_load(fuse_load),
		.fuse_div1_num(fuse_div1_num), .fuse_tag(fuse_tag), .fuse_spread_sel(fuse_spread_sel),
		.fuse_idle_sel(fuse_idle_sel), .product_revision(product_revision), .clk_ok(clk_ok),
		.ref_pin_level(ref_pin_level), .select1_pin_level(select1_pin_level),
		.select0_pin_level(select0_pin_level), .address_strap_level(address_strap_level),
		.ref_pin_func(ref_pin_func), .outputs_disabled(outputs_disabled),
		.divider1_numerator(div_o), .config_image_tag(tag_o), .spread_profile_select(spr_o),
		.spread_custom(spread_custom), .spread_preset(spread_preset),
		.ref_pin_out(ref_pin_out), .ref_pin_oe(ref_pin_oe), .outputs_mute(outputs_mute),
		.low_power(low_power), .preprog_mode(preprog_mode), .strap_addr(strap_addr),
		.strap_sel0(strap_sel0), .strap_sel1(strap_sel1), .lp_exit_pulse(lp_exit_pulse));

	always @(posedge core_clk) if (lp_exit_pulse === 1'b1) exits++;

	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	// bits 14:10 and 8:5 are live state, never the stored copy; bit 9 reads 0
	function automatic logic [15:0] exp_st();
		return {m_st[15], product_revision, clk_ok, 1'b0, ref_pin_level, select1_pin_level,
			select0_pin_level, address_strap_level, m_st[4:0]};
	endfunction : exp_st

	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		checked++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [15:0] want);
		logic [15:0] d;
		host_u.rd(a, d);
		chk(d, want);
	endtask : rdchk

	task automatic wrm(input logic [7:0] a, input logic [15:0] d);
		host_u.wr(a, d);
		if (a == 8'h08) m_div = d;
		if (a == 8'h09) m_tag = d[15:12];
		if (a == 8'h09) m_spr = d[11:9];
		if (a == 8'h0A) m_st = d & 16'h001F;
	endtask : wrm

	task automatic wait_lp(input logic want);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			#1;
			if (low_power === want) break;
		end
		chk({15'h0, low_power}, {15'h0, want});
	endtask : wait_lp

	task automatic tally_and_finish();
		if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		tally_and_finish();
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rdchk(8'h08, 16'hC28F);
		rdchk(8'h09, 16'h3000);
		rdchk(8'h0A, exp_st());
		rdchk(8'h0B, 16'h0000);
		chk({14'h0, spread_custom, spread_preset}, 16'h0002);
		for (int i = 0; i < 4; i++) begin
			lf = lfsr_next(lf);
			@(posedge core_clk);
			{clk_ok, ref_pin_level, select1_pin_level} <= lf[2:0];
			{select0_pin_level, address_strap_level, product_revision} <= lf[8:3];
			wrm(8'h08, lf);
			rdchk(8'h08, m_div);
			chk(div_o, m_div);
			rdchk(8'h0A, exp_st());
		end
		for (int s = 0; s < 8; s++) begin
			lf = lfsr_next(lf);
			wrm(8'h09, {lf[15:12], 3'(s), 9'h000});
			@(posedge core_clk);
			#1;
			chk({12'h0, spread_custom, spread_preset, 2'h0},
				{12'h0, s == 0, s >= 1 && s <= 4, 2'h0});
			chk({9'h0, tag_o, spr_o}, {9'h0, 4'(m_tag), 3'(m_spr)});
			rdchk(8'h09, {4'(m_tag), 3'(m_spr), 9'h000});
		end
		wrm(8'h0A, 16'h7FE0);
		rdchk(8'h0A, exp_st());
		wrm(8'h0A, 16'h0010);
		ref_pin_func <= 2'h3;
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			clk_ok <= (i == 4) ? clk_ok : ~clk_ok;
			ref_pin_func <= (i == 4) ? 2'h2 : 2'h3;
			@(posedge core_clk);
			#1;
			chk({14'h0, ref_pin_oe, ref_pin_out}, {14'h0, i != 4, (i != 4) && clk_ok});
		end
		// power-down, inhibited exit keeps serial-bus mode
		wrm(8'h0A, 16'h0012);
		wait_lp(1'b1);
		wrm(8'h0A, 16'h001A);
		address_strap_level <= 1'b1;
		wrm(8'h0A, 16'h0018);
		wait_lp(1'b0);
		chk({14'h0, preprog_mode, 1'b0}, 16'h0000);
		chk({13'h0, strap_addr, strap_sel1, strap_sel0}, 16'h0000);
		wrm(8'h0A, 16'h001A);
		wait_lp(1'b1);
		wrm(8'h0A, 16'h0012);
		wrm(8'h0A, 16'h0010);
		wait_lp(1'b0);
		chk({14'h0, preprog_mode, 1'b0}, 16'h0002);
		chk({13'h0, strap_addr, strap_sel1, strap_sel0},
			{13'h0, 1'b1, select1_pin_level, select0_pin_level});
		// the exit pulse is counted one edge after it rises
		@(posedge core_clk);
		#1;
		chk(16'(exits), 16'h0002);
		// idle into low power, then mute only
		wrm(8'h0A, 16'h0000);
		outputs_disabled <= 1'b1;
		wait_lp(1'b1);
		chk({15'h0, outputs_mute}, 16'h0001);
		@(posedge core_clk);
		outputs_disabled <= 1'b0;
		wait_lp(1'b0);
		wrm(8'h0A, 16'h0010);
		outputs_disabled <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk({14'h0, low_power, outputs_mute}, 16'h0001);
		lf = lfsr_next(lf);
		@(posedge core_clk);
		outputs_disabled <= 1'b0;
		{fuse_div1_num, fuse_tag, fuse_spread_sel, fuse_idle_sel} <= {lf, 4'hA, 3'h2, 1'b1};
		fuse_load <= 1'b1;
		@(posedge core_clk);
		fuse_load <= 1'b0;
		m_div = lf;
		m_tag = 'hA;
		m_spr = 2;
		rdchk(8'h08, m_div);
		rdchk(8'h09, 16'hA400);
		tally_and_finish();
	end
endmodule : clockgen_config_status_regs_tb_top
